// ---- core/pwm_time_base_interrupts.sv ----
// Behaviour
// RL1: overflow flag (bit 3) sets when the counter wraps from FFFFh to 0000h.
// RL2: phase flag (bit 2) sets when the counter equals the phase value.
// RL3: duty flag (bit 1) sets when the counter equals the duty cycle value.
// RL4: period flag (bit 0) sets when the counter equals the period value.
// RL5: overflow raises a request only while enable bit 7 is one.
// RL6: phase match raises a request only while enable bit 6 is one.
// RL7: duty match raises a request only while enable bit 5 is one.
// RL8: period match raises a request only while enable bit 4 is one.
// RL9: the four gated flags are ored into one time base request.
// RL10: flags stay set until software writes zero; writing one sets them.
//
// Chosen here: the register addresses and the Wishbone register port.
`timescale 1ns/1ns
module pwm_time_base_interrupts
(
   // clock and reset
   input wire logic MCLK_I,
   input wire logic RST_I,
   // wishbone slave
   input wire logic CYC_I,
   input wire logic STB_I,
   input wire logic WE_I,
   input wire logic [3:0] ADR_I,
   input wire logic [3:0] SEL_I,
   input wire logic [31:0] DAT_I,
   output logic [31:0] DAT_O,
   output logic ACK_O,
   // time base
   input wire logic [15:0] COUNTER_I,
   input wire logic [15:0] PHASE_I,
   input wire logic [15:0] DUTY_I,
   input wire logic [15:0] PERIOD_I,
   // interrupts
   output logic TIME_BASE_IRQ_O,
   output logic IRQ_O
);

   ////////////////////////////////////////////////////////////////////////
   tb_irq_pkg::time_base_t tb;
   tb_irq_pkg::src_bits_t flag_r;
   tb_irq_pkg::src_bits_t enable_r;
   tb_irq_pkg::src_bits_t hit;
   tb_irq_pkg::src_bits_t hit_last_r;
   tb_irq_pkg::src_bits_t rise;
   logic [3:0] status_r;
   logic [3:0] mask_r;
   logic [15:0] count_last_r;
   logic count_valid_r;
   logic req;
   logic wr;
   logic rd;
   logic lane0;

   // pack the compare inputs
   assign tb.time_base_counter = COUNTER_I;
   assign tb.phase_value = PHASE_I;
   assign tb.duty_cycle_value = DUTY_I;
   assign tb.period_value = PERIOD_I;

   // bus strobes; ack only in the first cycle so each access acts once
   assign req = CYC_I & STB_I & ~ACK_O;
   assign wr = req & WE_I;
   assign rd = req & ~WE_I;
   assign lane0 = SEL_I[0];

   ////////////////////////////////////////////////////////////////////////
   // previous counter, to see the wrap
   always_ff @(posedge MCLK_I)
   begin
      if (RST_I)
      begin
         count_last_r <= tb_irq_pkg::COUNT_ZERO;
         count_valid_r <= 1'b0;
      end
      else
      begin
         count_last_r <= tb.time_base_counter;
         count_valid_r <= 1'b1;
      end
   end

   // event detection; a match holding for many cycles sets once
   always_comb
   begin
      hit.overflow = count_valid_r &&
         count_last_r == tb_irq_pkg::COUNT_MAX &&
         tb.time_base_counter == tb_irq_pkg::COUNT_ZERO; // [RL1]
      hit.phase_match =
         tb.time_base_counter == tb.phase_value; // [RL2]
      hit.duty_match =
         tb.time_base_counter == tb.duty_cycle_value; // [RL3]
      hit.period_match =
         tb.time_base_counter == tb.period_value; // [RL4]
   end

   // match edges; overflow is already an edge
   always_ff @(posedge MCLK_I)
   begin
      if (RST_I)
         hit_last_r <= '0;
      else
         hit_last_r <= hit;
   end

   assign rise = hit & ~(hit_last_r & 4'b0111);

   ////////////////////////////////////////////////////////////////////////
   // control register: enables steer the request, flags are sticky
   always_ff @(posedge MCLK_I)
   begin
      if (RST_I)
      begin
         enable_r <= tb_irq_pkg::CONTROL_RESET[7:4];
         flag_r <= tb_irq_pkg::CONTROL_RESET[3:0];
      end
      else
      begin
         if (wr && lane0 && ADR_I == tb_irq_pkg::ADDR_CONTROL)
         begin
            enable_r <= DAT_I[tb_irq_pkg::ENABLE_LSB +: 4];
            // hardware set wins over a written zero
            flag_r <= DAT_I[tb_irq_pkg::FLAG_LSB +: 4] | rise; // [RL10]
         end
         else
            flag_r <= flag_r | rise; // [RL1] [RL2] [RL3] [RL4]
      end
   end

   // gated request per instance
   assign TIME_BASE_IRQ_O = |(flag_r & enable_r); // [RL5] [RL6] [RL7] [RL8] [RL9]

   ////////////////////////////////////////////////////////////////////////
   // system status: read clears, new request edge wins over the clear
   logic [3:0] src_edge;
   logic [3:0] gated_last_r;
   assign src_edge = (flag_r & enable_r) & ~gated_last_r;

   always_ff @(posedge MCLK_I)
   begin
      if (RST_I)
         gated_last_r <= '0;
      else
         gated_last_r <= flag_r & enable_r;
   end

   always_ff @(posedge MCLK_I)
   begin
      if (RST_I)
         status_r <= tb_irq_pkg::STATUS_RESET;
      else if (rd && ADR_I == tb_irq_pkg::ADDR_IRQ_STATUS)
         status_r <= src_edge;
      else
         status_r <= status_r | src_edge;
   end

   // mask register
   always_ff @(posedge MCLK_I)
   begin
      if (RST_I)
         mask_r <= tb_irq_pkg::MASK_RESET;
      else if (wr && lane0 && ADR_I == tb_irq_pkg::ADDR_IRQ_MASK)
         mask_r <= DAT_I[3:0];
   end

   assign IRQ_O = |(status_r & mask_r);

   ////////////////////////////////////////////////////////////////////////
   // ack and registered read data; unmapped reads give zero
   always_ff @(posedge MCLK_I)
   begin
      if (RST_I)
      begin
         ACK_O <= 1'b0;
         DAT_O <= tb_irq_pkg::READ_ZERO;
      end
      else
      begin
         ACK_O <= req;
         DAT_O <= tb_irq_pkg::READ_ZERO;
         if (rd)
         begin
            unique case (ADR_I)
               tb_irq_pkg::ADDR_CONTROL:
                  DAT_O[7:0] <= {enable_r, flag_r};
               tb_irq_pkg::ADDR_IRQ_STATUS:
                  DAT_O[3:0] <= status_r;
               tb_irq_pkg::ADDR_IRQ_MASK:
                  DAT_O[3:0] <= mask_r;
               default:
                  DAT_O <= tb_irq_pkg::READ_ZERO;
            endcase
         end
      end
   end

endmodule : pwm_time_base_interrupts

// ---- core/tb_irq_pkg.sv ----
package tb_irq_pkg;
   // register map, byte addresses on a 32-bit classic wishbone slave
   localparam logic [3:0] ADDR_CONTROL = 4'h0;
   localparam logic [3:0] ADDR_IRQ_STATUS = 4'h4;
   localparam logic [3:0] ADDR_IRQ_MASK = 4'h8;
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [3:0] STATUS_RESET = 4'h0;
   localparam logic [3:0] MASK_RESET = 4'h0;
   localparam logic [15:0] COUNT_MAX = 16'hFFFF;
   localparam logic [15:0] COUNT_ZERO = 16'h0000;
   localparam int FLAG_LSB = 0;
   localparam int ENABLE_LSB = 4;
   localparam int NUM_SRC = 4;
   localparam logic [31:0] READ_ZERO = 32'h0000_0000;

   // flag and enable nibbles share this order
   typedef struct packed
   {
      logic overflow;
      logic phase_match;
      logic duty_match;
      logic period_match;
   } src_bits_t;

   // compare inputs from the time base
   typedef struct packed
   {
      logic [15:0] time_base_counter;
      logic [15:0] phase_value;
      logic [15:0] duty_cycle_value;
      logic [15:0] period_value;
   } time_base_t;
endpackage : tb_irq_pkg

// ---- testbench/time_base_irq_checker.sv ----
`timescale 1ns/1ns
module time_base_irq_checker
(
   // watched ports
   input wire logic MCLK_I,
   input wire logic RST_I,
   input wire logic CYC_I,
   input wire logic STB_I,
   input wire logic WE_I,
   input wire logic [3:0] ADR_I,
   input wire logic [3:0] SEL_I,
   input wire logic [31:0] DAT_I,
   input wire logic [15:0] COUNTER_I,
   input wire logic [15:0] PHASE_I,
   input wire logic [15:0] DUTY_I,
   input wire logic [15:0] PERIOD_I,
   input wire logic ACK_O,
   input wire logic TIME_BASE_IRQ_O
);
   logic [3:0] en_r, eq_r, eq, hit;
   logic top_r, wr, t;
   // new equalities only: a held match sets once
   assign eq = {top_r & COUNTER_I == 16'h0000, COUNTER_I == PHASE_I,
      COUNTER_I == DUTY_I, COUNTER_I == PERIOD_I};
   assign hit = eq & ~eq_r & en_r;
   assign wr = CYC_I & STB_I & WE_I & ~ACK_O & ADR_I == 4'h0 & SEL_I[0];
   assign t = TIME_BASE_IRQ_O;
   // shadow enables; only taken writes move them
   always_ff @(posedge MCLK_I)
   begin
      top_r <= !RST_I & COUNTER_I == 16'hFFFF;
      eq_r <= RST_I ? 4'h0 : eq;
      en_r <= RST_I ? 4'h0 : wr ? DAT_I[7:4] : en_r;
   end
   ////////////////////////////////////////////////////////////////////
   default clocking @(posedge MCLK_I); endclocking
   default disable iff (RST_I);
   property p_ack; CYC_I & STB_I & !ACK_O |=> ACK_O; endproperty
   a_ack: assert property (p_ack) else $error("no ack");
   property p_one; ACK_O |=> !ACK_O; endproperty
   a_one: assert property (p_one) else $error("long ack");
   property p_ovf; hit[3] |=> t; endproperty
   a_ovf: assert property (p_ovf) else $error("ovf");
   property p_phs; hit[2] |=> t; endproperty
   a_phs: assert property (p_phs) else $error("phase");
   property p_dut; hit[1] |=> t; endproperty
   a_dut: assert property (p_dut) else $error("duty");
   property p_prd; hit[0] |=> t; endproperty
   a_prd: assert property (p_prd) else $error("period");
   property p_gate; en_r == 4'h0 |-> !t; endproperty
   a_gate: assert property (p_gate) else $error("gate");
   property p_hold; t & !wr |=> t; endproperty
   a_hold: assert property (p_hold) else $error("hold");
endmodule : time_base_irq_checker
bind pwm_time_base_interrupts time_base_irq_checker u_chk (.*);

// ---- testbench/testbench.sv ----
`timescale 1ns/1ns
module testbench;
   logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, we = 1'b0, ack, tbi, irq;
   logic [3:0] adr = 4'h0;
   logic [7:0] wd = 8'h00, f;
   logic [31:0] dat;
   logic [15:0] cnt = 16'h0000;
   logic [15:0] v [4] = '{16'h0030, 16'h0020, 16'h0010, 16'hFFFF};
   int failures = 0, total_checks = 0;
   // 20 MHz
   always #25 clk = ~clk;
   pwm_time_base_interrupts u_dut (.MCLK_I(clk), .RST_I(rst),
      .CYC_I(cyc), .STB_I(cyc), .WE_I(we), .ADR_I(adr), .SEL_I(4'hF),
      .DAT_I({24'h00_0000, wd}), .DAT_O(dat), .ACK_O(ack),
      .COUNTER_I(cnt), .PHASE_I(v[2]), .DUTY_I(v[1]), .PERIOD_I(v[0]),
      .TIME_BASE_IRQ_O(tbi), .IRQ_O(irq));
   task automatic chk(string n, logic [7:0] e, logic [7:0] s);
      total_checks++;
      failures += int'(s !== e);
      if (s !== e)
         $display("Error %s expected %h seen %h", n, e, s);
   endtask : chk
   // held until ack is sampled; the watchdog ends a hang
   task automatic bus(logic w, logic [3:0] a, logic [7:0] d);
      @(posedge clk);
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      wd <= d;
      @(posedge clk);
      while (ack !== 1'b1)
         @(posedge clk);
      cyc <= 1'b0;
   endtask : bus
   task automatic rc(logic [3:0] a, logic [7:0] e, string n);
      bus(1'b0, a, 8'h00);
      chk(n, e, dat[7:0]);
   endtask : rc
   // one sample at the value, settle past the wrap
   task automatic ev(int i);
      cnt <= v[i];
      @(posedge clk);
      cnt <= 16'h0000;
      repeat (3) @(negedge clk);
   endtask : ev
   task automatic wrap_up();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : wrap_up
   // per source: masked event, clear, enabled event
   initial
   begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      rc(4'h0, 8'h00, "ctl");
      bus(1'b1, 4'h8, 8'h0F);
      rc(4'h8, 8'h0F, "mask");
      for (int i = 0; i < 4; i++)
      begin
         f = 8'h01 << i;
         bus(1'b1, 4'h0, 8'hF0 ^ (f << 4));
         ev(i);
         chk("tbi", 8'h00, tbi);
         rc(4'h0, 8'hF0 ^ (f << 4) | f, "ctl");
         bus(1'b1, 4'h0, 8'hF0);
         chk("tbi", 8'h00, tbi);
         ev(i);
         chk("tbi", 8'h01, tbi);
         chk("irq", 8'h01, irq);
         rc(4'h4, f, "st");
         chk("irq", 8'h00, irq);
      end
      rc(4'hC, 8'h00, "unmapped");
      bus(1'b1, 4'h0, 8'h88);
      chk("tbi", 8'h01, tbi);
      wrap_up();
   end
   // hang guard
   initial
   begin
      #100000;
      failures++;
      wrap_up();
   end
endmodule : testbench
